// ---- src/serial_capture_pkg.sv ----
package serial_capture_pkg;

    // ----------------------------------------------------------------
    // capture modes
    // ----------------------------------------------------------------
    typedef enum logic {
        bit_clock_mode    = 1'b0,
        symbol_clock_mode = 1'b1
    } capture_mode_type;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int    REF_CLK_MHZ      = 200;
    localparam int    MAX_LINK_MHZ     = 50;
    localparam int    MAX_DATA_MBPS    = 50;
    // least ref_clk cycles per link clock phase at the top rate
    localparam int    MIN_HALF_CYCLES  = REF_CLK_MHZ / (2 * MAX_LINK_MHZ);
    // source divider default: half period in ref_clk cycles
    localparam int    SRC_HALF_DEFAULT = 4;

    // ----------------------------------------------------------------
    // widths and reset values
    // ----------------------------------------------------------------
    localparam int    BPS_WIDTH        = 4;
    localparam int    BPS_DEFAULT      = 2;
    localparam int    SYNC_STAGES      = 3;
    localparam logic  LINE_IDLE        = 1'b0;

endpackage

// ---- src/serial_link_if.sv ----
`timescale 1ns/1ps
interface serial_link_if;
    logic serial_data;
    logic bit_clock;
    logic symbol_marker;

    modport source (
        output serial_data,
        output bit_clock,
        output symbol_marker
    );
    modport capture (
        input  serial_data,
        input  bit_clock,
        input  symbol_marker
    );
endinterface

// ---- src/serial_symbol_capture.sv ----
// Behaviour
// - data line high means one, low zero
// - source at most 50 Mb/s; device accepts all
// - bit clock mode samples data on falling edge
// - symbol clock mode: marker falling edge clocks data
// - rising edge starts bit; capture on falling
// - bit clock and marker clock at most 50 MHz
// - marker high during first bit of symbol
// - accept repeated marker or single first pulse
// - source holds marker stable across falling edge
`timescale 1ns/1ps
module serial_symbol_capture #(
    parameter int BPS_WIDTH = serial_capture_pkg::BPS_WIDTH
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    // link pins
    serial_link_if.capture            link,
    // configuration
    input  wire serial_capture_pkg::capture_mode_type mode,
    input  wire logic [BPS_WIDTH-1:0] bits_per_symbol,
    // captured stream
    output logic                      bit_valid,
    output logic                      bit_value,
    output logic                      symbol_start,
    output logic [BPS_WIDTH-1:0]      bit_index,
    output logic                      symbol_done,
    output logic                      aligned
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // three stages per pin; a change counts once stages two and three
    // agree, so stage one is read only by stage two
    localparam int NS = serial_capture_pkg::SYNC_STAGES;
    localparam logic [NS-1:0] SYNC_IDLE = {NS{serial_capture_pkg::LINE_IDLE}};
    logic [NS-1:0] data_sync_q;
    logic [NS-1:0] clk_sync_q;
    logic [NS-1:0] mark_sync_q;
    logic          clk_lvl_q;
    logic          mark_lvl_q;
    logic          data_lvl_q;

    // stages two and three agree: the pin has settled
    function automatic logic settled(input logic [NS-1:0] stages);
        return stages[NS-2] == stages[NS-1];
    endfunction

    // settled pin now low while its filtered level is still high
    function automatic logic falls(input logic [NS-1:0] stages,
                                   input logic          level);
        return settled(stages) && level && !stages[NS-1];
    endfunction

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            data_sync_q <= SYNC_IDLE;
        else
            data_sync_q <= {data_sync_q[NS-2:0], link.serial_data};
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            clk_sync_q <= SYNC_IDLE;
        else
            clk_sync_q <= {clk_sync_q[NS-2:0], link.bit_clock};
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            mark_sync_q <= SYNC_IDLE;
        else
            mark_sync_q <= {mark_sync_q[NS-2:0], link.symbol_marker};
    end

    wire clk_settled  = settled(clk_sync_q);
    wire mark_settled = settled(mark_sync_q);
    wire data_settled = settled(data_sync_q);

    // a pulse shorter than two ref_clk cycles never moves a level
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            clk_lvl_q <= serial_capture_pkg::LINE_IDLE;
        else if (clk_settled)
            clk_lvl_q <= clk_sync_q[NS-1];
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            mark_lvl_q <= serial_capture_pkg::LINE_IDLE;
        else if (mark_settled)
            mark_lvl_q <= mark_sync_q[NS-1];
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            data_lvl_q <= serial_capture_pkg::LINE_IDLE;
        else if (data_settled)
            data_lvl_q <= data_sync_q[NS-1];
    end

    // ----------------------------------------------------------------
    // configuration decode
    // ----------------------------------------------------------------
    // mode and symbol length are levels; change them only while the
    // link is idle, or one bit may be counted under the old setting
    wire                 sym_mode = mode
                                    == serial_capture_pkg::symbol_clock_mode;
    wire [BPS_WIDTH-1:0] last_idx = bits_per_symbol - BPS_WIDTH'(1);

    // ----------------------------------------------------------------
    // edge detection and sampling
    // ----------------------------------------------------------------
    // data and marker filtered levels lag by the same stages as the
    // clock, so at a detected falling edge they still show the values
    // that stood across the pin edge; at 50 MHz a phase is two ref_clk
    // cycles, the least the filter passes
    wire clk_fall  = falls(clk_sync_q, clk_lvl_q);
    wire mark_fall = falls(mark_sync_q, mark_lvl_q);

    wire take_bit  = sym_mode ? mark_fall : clk_fall;
    // the filtered data level holds the value sampled at the edge
    wire sample    = data_lvl_q;
    // in symbol clock mode every marker falling edge opens a symbol
    wire marked    = sym_mode ? 1'b1 : mark_lvl_q;

    // ----------------------------------------------------------------
    // symbol counter
    // ----------------------------------------------------------------
    logic [BPS_WIDTH-1:0] idx_q;
    logic [BPS_WIDTH-1:0] idx_d;
    logic                 aligned_q;
    logic                 seen_q;

    wire                 at_last  = idx_q >= last_idx;
    // a bit opens a symbol on a marker, or once a counted symbol is full
    wire                 opens    = marked || (aligned_q && at_last);
    // the first bit after reset has nothing to follow: index 0
    wire                 restart  = opens || !seen_q;

    // a single marker is enough: the count free-runs afterwards
    assign idx_d = restart ? '0 : idx_q + BPS_WIDTH'(1);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            idx_q <= '0;
        else if (take_bit)
            idx_q <= idx_d;
    end

    // once set, only reset clears it: a lost marker keeps the old count
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            aligned_q <= 1'b0;
        else if (take_bit && marked)
            aligned_q <= 1'b1;
    end

    // any bit taken since reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            seen_q <= 1'b0;
        else if (take_bit)
            seen_q <= 1'b1;
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    wire start_now   = take_bit && opens;
    // no symbol can close before a marker has fixed where it starts
    wire done_now    = take_bit && (aligned_q || marked)
                       && (idx_d == last_idx);
    wire now_aligned = aligned_q || (take_bit && marked);

    // per-bit pulses
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bit_valid    <= 1'b0;
            symbol_start <= 1'b0;
            symbol_done  <= 1'b0;
        end else begin
            bit_valid    <= take_bit;
            symbol_start <= start_now;
            symbol_done  <= done_now;
        end
    end

    // values that hold until the next bit
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bit_value <= 1'b0;
            bit_index <= '0;
        end else if (take_bit) begin
            bit_value <= sample;
            bit_index <= idx_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            aligned <= 1'b0;
        else
            aligned <= now_aligned;
    end

endmodule

// ---- src/serial_symbol_source.sv ----
`timescale 1ns/1ps
module serial_symbol_source #(
    parameter int HALF_CYCLES = serial_capture_pkg::SRC_HALF_DEFAULT,
    parameter int BPS_WIDTH   = serial_capture_pkg::BPS_WIDTH
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    // link pins
    serial_link_if.source             link,
    // configuration
    input  wire serial_capture_pkg::capture_mode_type mode,
    input  wire logic [BPS_WIDTH-1:0] bits_per_symbol,
    input  wire logic                 marker_once,
    // user stream
    input  wire logic                 bit_in_valid,
    input  wire logic                 bit_in,
    output logic                      bit_in_ready
);

    // ----------------------------------------------------------------
    // bit clock divider
    // ----------------------------------------------------------------
    // HALF_CYCLES below MIN_HALF_CYCLES would exceed the link limit
    localparam int HC = (HALF_CYCLES < serial_capture_pkg::MIN_HALF_CYCLES)
                        ? serial_capture_pkg::MIN_HALF_CYCLES
                        : HALF_CYCLES;
    localparam int CW = $clog2(HC + 1);

    logic [CW-1:0]        div_q;
    logic                 phase_q;   // 0 = low half, 1 = high half
    logic                 busy_q;
    logic [BPS_WIDTH-1:0] idx_q;
    logic                 first_q;

    wire half_end = div_q == CW'(HC - 1);
    wire start    = !busy_q && bit_in_valid;
    wire sym_mode = mode == serial_capture_pkg::symbol_clock_mode;
    wire first_of = idx_q == '0;
    wire last_of  = idx_q >= bits_per_symbol - BPS_WIDTH'(1);
    wire mark_bit = first_of && (!marker_once || first_q);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_q   <= '0;
            phase_q <= 1'b0;
            busy_q  <= 1'b0;
            idx_q   <= '0;
            first_q <= 1'b1;
        end else if (start) begin
            div_q   <= '0;
            phase_q <= 1'b1;
            busy_q  <= 1'b1;
        end else if (busy_q && half_end) begin
            div_q   <= '0;
            phase_q <= !phase_q;
            if (!phase_q) begin
                busy_q  <= 1'b0;
                idx_q   <= last_of ? '0 : idx_q + BPS_WIDTH'(1);
                if (first_of)
                    first_q <= 1'b0;
            end
        end else if (busy_q) begin
            div_q <= div_q + CW'(1);
        end
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    // data changes with the rising clock edge (marker edge in symbol clock mode) and stays across the fall
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            link.serial_data   <= 1'b0;
            link.bit_clock     <= 1'b0;
            link.symbol_marker <= 1'b0;
            bit_in_ready       <= 1'b0;
        end else begin
            bit_in_ready <= !busy_q && !bit_in_valid;
            if (start) begin
                link.serial_data <= bit_in;
                link.bit_clock   <= !sym_mode;
                // symbol clock mode: marker rises with the bit, falls mid
                link.symbol_marker <= sym_mode ? 1'b1 : mark_bit;
            end else if (busy_q && half_end && phase_q) begin
                link.bit_clock <= 1'b0;
                if (sym_mode)
                    link.symbol_marker <= 1'b0;
            end else if (busy_q && half_end && !sym_mode) begin
                link.symbol_marker <= 1'b0;
            end
        end
    end

endmodule

// ---- tb/serial_link_checker.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// link wire checks, figures for a source half period of 2 cycles
// ----------------------------------------------------------------
module serial_link_checker (
    // clock and reset
    input wire logic                              ref_clk,
    input wire logic                              rstn,
    // link pins
    input wire logic                              serial_data,
    input wire logic                              bit_clock,
    input wire logic                              symbol_marker,
    // configuration
    input wire serial_capture_pkg::capture_mode_type mode
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    a_clock_high_width: assert property (
        $rose(bit_clock) |-> bit_clock [*2] ##1 !bit_clock)
        else $error("bit clock high phase has the wrong width");
    a_clock_low_width: assert property (
        $fell(bit_clock) |-> !bit_clock [*2])
        else $error("bit clock low phase too short");
    a_data_hold_fall: assert property (
        $fell(bit_clock) |-> $stable(serial_data) ##1 $stable(serial_data))
        else $error("data moved around the bit clock fall");
    a_data_moves_rise: assert property (
        mode == serial_capture_pkg::bit_clock_mode && $changed(serial_data)
        |-> $rose(bit_clock))
        else $error("data changed away from a bit start");
    a_marker_hold: assert property (
        mode == serial_capture_pkg::bit_clock_mode && $fell(bit_clock)
        |-> $stable(symbol_marker) ##1 $stable(symbol_marker))
        else $error("marker moved around the bit clock fall");
    a_marker_first_bit: assert property (
        mode == serial_capture_pkg::bit_clock_mode && $rose(symbol_marker)
        |-> $rose(bit_clock))
        else $error("marker rose away from a bit start");
    a_symbol_data_hold: assert property (
        mode == serial_capture_pkg::symbol_clock_mode && $fell(symbol_marker)
        |-> $stable(serial_data) ##1 $stable(serial_data))
        else $error("data moved around the marker fall");
    a_symbol_clocks_bit: assert property (
        mode == serial_capture_pkg::symbol_clock_mode
        && $changed(serial_data) |-> $rose(symbol_marker))
        else $error("symbol mode bit without a marker clock");
    a_idle_after_reset: assert property (
        $rose(rstn) |-> !bit_clock && !symbol_marker && !serial_data)
        else $error("link lines not idle after reset");
endmodule

// ---- tb/external_serial_symbol_data_capture_tb_top.sv ----
`timescale 1ns/1ps
module external_serial_symbol_data_capture_tb_top;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic                                 ref_clk = 1'b0;
    logic                                 rstn = 1'b0;
    serial_capture_pkg::capture_mode_type mode =
                                          serial_capture_pkg::bit_clock_mode;
    logic [3:0]                           bits_per_symbol = 4'h3;
    logic                                 marker_once = 1'b0;
    logic                                 bit_in_valid = 1'b0;
    logic                                 bit_in = 1'b0;
    logic                                 bit_in_ready;
    logic                                 bit_valid;
    logic                                 bit_value;
    logic                                 symbol_start;
    logic                                 symbol_done;
    logic                                 aligned;
    logic [3:0]                           bit_index;
    int                                   failures = 0;
    int                                   comparisons = 0;

    serial_link_if link ();
    always #2.5 ref_clk = ~ref_clk;

    // top link rate: 5 cycles per bit, 40 Mb/s
    serial_symbol_source #(.HALF_CYCLES(2)) u_serial_symbol_source (
        .ref_clk(ref_clk), .rstn(rstn), .link(link), .mode(mode),
        .bits_per_symbol(bits_per_symbol), .marker_once(marker_once),
        .bit_in_valid(bit_in_valid), .bit_in(bit_in),
        .bit_in_ready(bit_in_ready));
    serial_symbol_capture u_serial_symbol_capture (
        .ref_clk(ref_clk), .rstn(rstn), .link(link), .mode(mode),
        .bits_per_symbol(bits_per_symbol), .bit_valid(bit_valid),
        .bit_value(bit_value), .symbol_start(symbol_start),
        .bit_index(bit_index), .symbol_done(symbol_done),
        .aligned(aligned));
    serial_link_checker u_serial_link_checker (
        .ref_clk(ref_clk), .rstn(rstn), .serial_data(link.serial_data),
        .bit_clock(link.bit_clock), .symbol_marker(link.symbol_marker),
        .mode(mode));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset(input logic once);
        @(posedge ref_clk);
        #1 rstn = 1'b0;
        marker_once = once;
        repeat (16) @(posedge ref_clk);
        #1 rstn = 1'b1;
        @(posedge ref_clk);
        #1;
        check({3'h0, aligned}, 4'h0);
    endtask

    // hands one bit to the source, then judges what the capture shows
    task automatic send_bit(input logic b, input logic [3:0] idx,
                            input logic st, input logic dn);
        int n;
        n = 0;
        while (bit_in_ready !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            #1 n++;
        end
        bit_in = b;
        bit_in_valid = 1'b1;
        @(posedge ref_clk);
        #1 bit_in_valid = 1'b0;
        n = 0;
        while (bit_valid !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            #1 n++;
        end
        check({3'h0, bit_valid}, 4'h1);
        check({3'h0, bit_value}, {3'h0, b});
        check(bit_index, idx);
        check({2'h0, symbol_start, symbol_done}, {2'h0, st, dn});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_repeated_marker;
        int k;
        int i;
        mode = serial_capture_pkg::bit_clock_mode;
        for (k = 1; k <= 4; k++) begin
            bits_per_symbol = 4'(k);
            do_reset(1'b0);
            for (i = 0; i < 2 * k; i++)
                send_bit(i[0] ^ i[1], 4'(i % k), i % k == 0,
                         i % k == k - 1);
        end
        check({3'h0, aligned}, 4'h1);
        $display("test repeated_marker done");
    endtask

    task automatic t_single_marker;
        int i;
        bits_per_symbol = 4'h4;
        do_reset(1'b1);
        for (i = 0; i < 10; i++)
            send_bit(i[1], 4'(i % 4), i % 4 == 0, i % 4 == 3);
        check({3'h0, aligned}, 4'h1);
        $display("test single_marker done");
    endtask

    task automatic t_symbol_clock;
        int i;
        mode = serial_capture_pkg::symbol_clock_mode;
        do_reset(1'b0);
        for (i = 0; i < 6; i++) begin
            // a one-bit symbol closes with every marker clock
            bits_per_symbol = (i < 3) ? 4'h4 : 4'h1;
            send_bit(i[0], 4'h0, 1'b1, i >= 3);
        end
        $display("test symbol_clock done");
    endtask

    task automatic give_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        t_repeated_marker();
        t_single_marker();
        t_symbol_clock();
        give_verdict();
    end

    // about 28 times the expected run
    initial begin
        #50000;
        failures++;
        give_verdict();
    end
endmodule
